// ===== rtl/sensor_result_status_regs.sv
// result, parameter read-back and chip state registers of the sensor register map
// assumes the serial front end and the measurement sequencer run on ref_clk_i
//
// What this block does
// - ir light result high byte at 0x25, low byte at 0x24.
// - proximity one result: low byte 0x26, high byte 0x27.
// - proximity two result: low byte 0x28, high byte 0x29.
// - proximity three result: low byte 0x2A, high byte 0x2B.
// - extra channel result: low byte 0x2C, high byte 0x2D.
// - mailbox at 0x2E returns a parameter value from sequencer to host.
// - chip state bit 0 is sleep, bit 2 is awake, bits 7:3 zero.
// - chip state bit 1 set while suspended waiting for a measurement.
// - all results, mailbox and chip state reset to zero.
// - interrupt output asserts when any pending flag has its enable set.
`timescale 1ns/1ps

module sensor_result_status_regs (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        meas_done_i,
  input  wire logic [2:0]  meas_chan_i,
  input  wire logic [15:0] meas_value_i,
  input  wire logic        param_load_i,
  input  wire logic [7:0]  param_value_i,
  input  wire logic [1:0]  power_state_i,
  input  wire logic [7:0]  irq_status_i,
  input  wire logic [7:0]  irq_enable_i,
  output logic             irq_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [sensor_result_pkg::NUM_CHAN-1:0][15:0] result;
    logic [7:0]                                   mailbox;
    logic [7:0]                                   chip_stat;
    logic [7:0]                                   rdata;
    logic                                         irq;
  } state_t;

  state_t cur;
  state_t next_cur;
  sensor_result_pkg::power_state_t pwr;

  assign pwr = sensor_result_pkg::power_state_t'(power_state_i);

  // ==========================================================
  // next state
  // a sequencer load beats a host write in the same cycle so a sample is never torn
  always_comb begin
    logic [7:0] lo_addr;
    logic [7:0] rd_val;
    lo_addr  = 8'h00;
    rd_val   = 8'h00;
    next_cur = cur;
    for (int ch = 0; ch < sensor_result_pkg::NUM_CHAN; ch++) begin
      lo_addr = 8'(sensor_result_pkg::ADDR_RESULT_BASE + 8'(2 * ch));
      if (reg_wr_i && reg_addr_i == lo_addr) begin
        next_cur.result[ch][7:0] = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == 8'(lo_addr + 8'h01)) begin
        next_cur.result[ch][15:8] = reg_wdata_i;
      end
      if (meas_done_i && meas_chan_i == 3'(ch)) begin
        next_cur.result[ch] = meas_value_i;
      end
      if (reg_addr_i == lo_addr) begin
        rd_val = cur.result[ch][7:0];
      end
      if (reg_addr_i == 8'(lo_addr + 8'h01)) begin
        rd_val = cur.result[ch][15:8];
      end
    end
    // mailbox: host may write, the sequencer's answer wins
    if (reg_wr_i && reg_addr_i == sensor_result_pkg::ADDR_PARAM_READBACK_MAILBOX) begin
      next_cur.mailbox = reg_wdata_i;
    end
    if (param_load_i) begin
      next_cur.mailbox = param_value_i;
    end
    if (reg_addr_i == sensor_result_pkg::ADDR_PARAM_READBACK_MAILBOX) begin
      rd_val = cur.mailbox;
    end
    // chip state is read only; host writes to it are dropped
    next_cur.chip_stat = sensor_result_pkg::BYTE_RESET;
    next_cur.chip_stat[sensor_result_pkg::STAT_SLEEP]   = (pwr == sensor_result_pkg::PWR_SLEEP);
    next_cur.chip_stat[sensor_result_pkg::STAT_SUSPEND] = (pwr == sensor_result_pkg::PWR_SUSPEND);
    next_cur.chip_stat[sensor_result_pkg::STAT_RUNNING] = (pwr == sensor_result_pkg::PWR_RUNNING);
    if (reg_addr_i == sensor_result_pkg::ADDR_CHIP_POWER_STATE) begin
      rd_val = cur.chip_stat;
    end
    // read data holds until the next read strobe; unmapped offsets read zero
    if (reg_rd_i) begin
      next_cur.rdata = rd_val;
    end
    next_cur.irq = |(irq_status_i & irq_enable_i);
  end

  // ==========================================================
  // registers; everything clears to zero
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata_o = cur.rdata;
  assign irq_o       = cur.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence read_at_s(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence

  // a measurement replaces the whole word in one cycle
  word_load_a: assert property (
    meas_done_i && meas_chan_i < 3'(sensor_result_pkg::NUM_CHAN)
    |=> cur.result[$past(meas_chan_i)] == $past(meas_value_i))
    else $error("result word not loaded whole");

  ir_high_read_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_IR_LIGHT_RESULT_HIGH)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_IR][15:8]))
    else $error("ir high byte read wrong");

  prox_one_read_a: assert property (
    meas_done_i && meas_chan_i == sensor_result_pkg::CHAN_PROX1 && !reg_wr_i
    ##1 read_at_s(sensor_result_pkg::ADDR_PROX_ONE_RESULT_LOW)
    |=> reg_rdata_o == $past(meas_value_i[7:0], 2))
    else $error("proximity one low byte read wrong");

  prox_two_read_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_PROX_TWO_RESULT_HIGH)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_PROX2][15:8]))
    else $error("proximity two high byte read wrong");

  prox_three_read_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_PROX_THREE_RESULT_LOW)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_PROX3][7:0]))
    else $error("proximity three low byte read wrong");

  extra_read_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_EXTRA_CHANNEL_HIGH)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_EXTRA][15:8]))
    else $error("extra channel high byte read wrong");

  mailbox_load_a: assert property (
    param_load_i ##1 read_at_s(sensor_result_pkg::ADDR_PARAM_READBACK_MAILBOX)
    |=> reg_rdata_o == $past(param_value_i, 2))
    else $error("mailbox does not return parameter");

  chip_sleep_a: assert property (
    pwr == sensor_result_pkg::PWR_SLEEP |=> cur.chip_stat == 8'h01)
    else $error("sleep state not reported");

  chip_suspend_a: assert property (
    pwr == sensor_result_pkg::PWR_SUSPEND |=> cur.chip_stat == 8'h02)
    else $error("suspend state not reported");

  irq_follow_a: assert property (
    |(irq_status_i & irq_enable_i) |=> irq_o)
    else $error("interrupt not raised for enabled flag");

  // ==========================================================
  // further checks on the interrupt, chip state and read paths

  // the interrupt must also fall, or a stuck line would go unnoticed
  irq_drop_a: assert property (
    !(|(irq_status_i & irq_enable_i)) |=> !irq_o)
    else $error("interrupt stays up with no enabled flag");

  // awake reports bit 2 alone
  chip_running_a: assert property (
    pwr == sensor_result_pkg::PWR_RUNNING |=> cur.chip_stat == 8'h04)
    else $error("running state not reported");

  // no known state means no flag at all
  chip_off_a: assert property (
    pwr == sensor_result_pkg::PWR_OFF |=> cur.chip_stat == 8'h00)
    else $error("off state reports a flag");

  // host writes to the read-only byte must not disturb it
  chip_write_drop_a: assert property (
    reg_wr_i && reg_addr_i == sensor_result_pkg::ADDR_CHIP_POWER_STATE
    && pwr == sensor_result_pkg::PWR_SLEEP |=> cur.chip_stat == 8'h01)
    else $error("chip state took a host write");

  // read of the chip state returns the registered flags
  chip_read_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_CHIP_POWER_STATE)
    |=> reg_rdata_o == $past(cur.chip_stat))
    else $error("chip state read wrong");

  ir_low_read_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_RESULT_BASE)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_IR][7:0]))
    else $error("ir low byte read wrong");

  prox_one_high_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_PROX_ONE_RESULT_HIGH)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_PROX1][15:8]))
    else $error("proximity one high byte read wrong");

  prox_two_low_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_PROX_TWO_RESULT_LOW)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_PROX2][7:0]))
    else $error("proximity two low byte read wrong");

  prox_three_high_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_PROX_THREE_RESULT_HIGH)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_PROX3][15:8]))
    else $error("proximity three high byte read wrong");

  extra_low_read_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_EXTRA_CHANNEL_LOW)
    |=> reg_rdata_o == $past(cur.result[sensor_result_pkg::CHAN_EXTRA][7:0]))
    else $error("extra channel low byte read wrong");

  mailbox_read_a: assert property (
    read_at_s(sensor_result_pkg::ADDR_PARAM_READBACK_MAILBOX)
    |=> reg_rdata_o == $past(cur.mailbox))
    else $error("mailbox read wrong");

  // a host write lands only when the sequencer is not loading
  mailbox_write_a: assert property (
    reg_wr_i && reg_addr_i == sensor_result_pkg::ADDR_PARAM_READBACK_MAILBOX
    && !param_load_i |=> cur.mailbox == $past(reg_wdata_i))
    else $error("mailbox host write lost");

  // a same-cycle host write must not tear a fresh sample
  load_wins_a: assert property (
    meas_done_i && meas_chan_i == sensor_result_pkg::CHAN_PROX2
    && reg_wr_i && reg_addr_i == sensor_result_pkg::ADDR_PROX_TWO_RESULT_LOW
    |=> cur.result[sensor_result_pkg::CHAN_PROX2] == $past(meas_value_i))
    else $error("host write tore a measurement");

  // channel codes past the last word are ignored
  chan_refuse_a: assert property (
    meas_done_i && meas_chan_i >= 3'(sensor_result_pkg::NUM_CHAN) && !reg_wr_i
    |=> $stable(cur.result))
    else $error("unused channel code changed a result");

  // read data stands until the next read strobe
  rdata_hold_a: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");

  // the gap between mailbox and chip state reads as zero
  unmapped_read_a: assert property (
    read_at_s(8'(sensor_result_pkg::ADDR_PARAM_READBACK_MAILBOX + 8'h01))
    |=> reg_rdata_o == sensor_result_pkg::BYTE_RESET)
    else $error("unmapped offset read nonzero");

endmodule

// ===== rtl/sensor_result_pkg.sv
// constants for the sensor result and chip state register bank
// assumes a byte-wide register port driven by the serial front end on the same clock
package sensor_result_pkg;

  // ==========================================================
  // channels
  localparam int          NUM_CHAN     = 5;
  localparam logic [2:0]  CHAN_IR      = 3'h0;
  localparam logic [2:0]  CHAN_PROX1   = 3'h1;
  localparam logic [2:0]  CHAN_PROX2   = 3'h2;
  localparam logic [2:0]  CHAN_PROX3   = 3'h3;
  localparam logic [2:0]  CHAN_EXTRA   = 3'h4;

  // ==========================================================
  // register offsets
  localparam logic [7:0]  ADDR_RESULT_BASE            = 8'h24;
  localparam logic [7:0]  ADDR_IR_LIGHT_RESULT_HIGH   = 8'h25;
  localparam logic [7:0]  ADDR_PROX_ONE_RESULT_LOW    = 8'h26;
  localparam logic [7:0]  ADDR_PROX_ONE_RESULT_HIGH   = 8'h27;
  localparam logic [7:0]  ADDR_PROX_TWO_RESULT_LOW    = 8'h28;
  localparam logic [7:0]  ADDR_PROX_TWO_RESULT_HIGH   = 8'h29;
  localparam logic [7:0]  ADDR_PROX_THREE_RESULT_LOW  = 8'h2A;
  localparam logic [7:0]  ADDR_PROX_THREE_RESULT_HIGH = 8'h2B;
  localparam logic [7:0]  ADDR_EXTRA_CHANNEL_LOW      = 8'h2C;
  localparam logic [7:0]  ADDR_EXTRA_CHANNEL_HIGH     = 8'h2D;
  localparam logic [7:0]  ADDR_PARAM_READBACK_MAILBOX = 8'h2E;
  localparam logic [7:0]  ADDR_CHIP_POWER_STATE       = 8'h30;

  // ==========================================================
  // reset values and chip state fields
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam int          STAT_SLEEP    = 0;
  localparam int          STAT_SUSPEND  = 1;
  localparam int          STAT_RUNNING  = 2;

  // power state reported by the sequencer
  typedef enum logic [1:0] {
    PWR_OFF     = 2'b00,
    PWR_SLEEP   = 2'b01,
    PWR_SUSPEND = 2'b10,
    PWR_RUNNING = 2'b11
  } power_state_t;

endpackage

// ===== dv/host_port_model.sv
// ==========================================
// host side of the byte strobe register port
// assumes clk_i is the block clock; requests change 1 ns after its rising edge
`timescale 1ns/1ps
module host_port_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o,
  output logic            rd_o
);
  // idle port: strobes low, address and data inverted so stale values never look valid
  initial begin
    addr_o = 8'hFF;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one access per call; read data taken one edge after the strobe edge
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge clk_i);
    #1;
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

// ===== dv/tb.sv
// ==========================================
// self-checking bench for the result and chip state registers
// assumes the sequencer side is driven here and the host side by host_port_model
`timescale 1ns/1ps
module tb;
  logic ref_clk_i, reset_n_i, meas_done_i, param_load_i, irq_o, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, param_value_i, irq_status_i, irq_enable_i;
  logic [2:0] meas_chan_i;
  logic [15:0] meas_value_i, v;
  logic [15:0] word [5];
  logic [1:0] power_state_i;
  logic [7:0] a, q, d;
  int errors, num_checks;
  sensor_result_status_regs sensor_result_status_regs_inst (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .meas_done_i(meas_done_i), .meas_chan_i(meas_chan_i), .meas_value_i(meas_value_i),
    .param_load_i(param_load_i), .param_value_i(param_value_i),
    .power_state_i(power_state_i), .irq_status_i(irq_status_i),
    .irq_enable_i(irq_enable_i), .irq_o(irq_o));
  host_port_model host_port_model_inst (.clk_i(ref_clk_i), .rdata_i(reg_rdata_o),
    .addr_o(reg_addr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i), .rd_o(reg_rd_i));
  // 40 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // stimulus; sequencer strobes last one cycle each
  initial begin
    {reset_n_i, meas_done_i, meas_chan_i, meas_value_i, param_load_i} = '0;
    {param_value_i, power_state_i, irq_status_i, irq_enable_i} = '0;
    for (int i = 0; i < 5; i++) word[i] = 16'h0000;
    void'($urandom(32'hf8f9));
    repeat (4) @(posedge ref_clk_i);
    #1 reset_n_i = 1'b1;
    // whole map after reset, unmapped 0x2F and 0x31 included
    for (int i = 8'h24; i <= 8'h31; i++) begin
      host_port_model_inst.access(1'b0, i[7:0], 8'h00, q);
      check(q, 8'h00);
    end
    // one load per channel code, 5..7 must leave every word alone
    for (int c = 0; c < 8; c++) begin
      v = $urandom;
      @(posedge ref_clk_i);
      #1 {meas_done_i, meas_chan_i, meas_value_i} = {1'b1, c[2:0], v};
      @(posedge ref_clk_i);
      #1 meas_done_i = 1'b0;
      if (c < 5) word[c] = v;
      // host drains all bytes before the next load
      for (int k = 0; k < 10; k++) begin
        a = sensor_result_pkg::ADDR_RESULT_BASE + 8'(k);
        host_port_model_inst.access(1'b0, a, 8'h00, q);
        check(q, word[k / 2][8 * (k % 2) +: 8]);
      end
    end
    // mailbox: sequencer load, then host write
    d = $urandom;
    @(posedge ref_clk_i);
    #1 {param_load_i, param_value_i} = {1'b1, d};
    @(posedge ref_clk_i);
    #1 param_load_i = 1'b0;
    host_port_model_inst.access(1'b0, 8'h2E, 8'h00, q);
    check(q, d);
    host_port_model_inst.access(1'b1, 8'h2E, ~d, q);
    host_port_model_inst.access(1'b0, 8'h2E, 8'h00, q);
    check(q, ~d);
    // chip state per power code; the write must not stick
    for (int p = 0; p < 4; p++) begin
      power_state_i = p[1:0];
      host_port_model_inst.access(1'b1, 8'h30, 8'hFF, q);
      host_port_model_inst.access(1'b0, 8'h30, 8'h00, q);
      check(q, (p == 0) ? 8'h00 : 8'h01 << (p - 1));
    end
    // interrupt: corner of all flags with no enables, then random pairs
    for (int i = 0; i < 24; i++) begin
      @(posedge ref_clk_i);
      #1 irq_status_i = (i == 0) ? 8'hFF : 8'($urandom);
      irq_enable_i = (i == 0) ? 8'h00 : 8'($urandom) & 8'($urandom);
      @(posedge ref_clk_i);
      #1 check({7'h00, irq_o}, {7'h00, |(irq_status_i & irq_enable_i)});
    end
    test_done();
  end
endmodule
